// ===== hw/fcd_arb.sv
// arbiter: picks one waiting channel and weighs it against the processor
// assumes want is only raised while the engine is idle
`timescale 1ns/1ps
`default_nettype none
module fcd_arb #(
  parameter int NCH = 5
) (
  input wire logic mclk, // system clock
  input wire logic reset, // sync reset, high
  input wire logic ce, // clock enable
  input wire logic [NCH-1:0] want, // channels asking
  input wire logic [2*NCH-1:0] prio, // two bits per channel
  input wire logic cpu_req, // processor memory access
  output logic gnt_vld, // a channel may go
  output logic [2:0] gnt_ch // chosen channel
);
  logic [2:0] rr_ff;
  logic turn_ff;
  logic [1:0] top;
  logic found;
  logic [2:0] ch;

  function automatic logic [1:0] pr(input logic [2*NCH-1:0] p, input int i);
    return p[2*i +: 2];
  endfunction

  always_comb begin
    int idx;
    idx = 0;
    top = fcd_pkg::PRIO_LOW;
    found = 1'b0;
    ch = 3'h0;
    for (int i = 0; i < NCH; i++) begin
      if (want[i] && pr(prio, i) > top) begin
        top = pr(prio, i);
      end
    end
    for (int k = 0; k < NCH; k++) begin
      idx = (int'(rr_ff) + k) % NCH;
      if (!found && want[idx] && pr(prio, idx) == top) begin
        found = 1'b1;
        ch = 3'(idx);
      end
    end
  end

  // high beats the core, normal every second try, low yields
  assign gnt_vld = found && (top == fcd_pkg::PRIO_HIGH || !cpu_req ||
                   (top == fcd_pkg::PRIO_NORM && turn_ff));
  assign gnt_ch = ch;

  always_ff @(posedge mclk) begin
    if (reset) begin
      rr_ff <= 3'h0;
      turn_ff <= 1'b0;
    end else if (ce) begin
      if (gnt_vld) begin
        rr_ff <= (ch == 3'(NCH - 1)) ? 3'h0 : ch + 3'h1;
      end
      if (found && cpu_req && top == fcd_pkg::PRIO_NORM) begin
        turn_ff <= ~turn_ff;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/fcd_dma.sv
// five channel dma controller: apb registers, trigger logic, engine
// assumes a memory port that acks each request with a one-cycle pulse
//
// Behaviour
// - five channels, each moving memory to memory
// - unarmed channel ignores triggers entirely
// - arming loads configuration in nine cycles
// - during loading old trigger still matches
// - several arms load serially, one first
// - one of events 1 to 29 triggers each channel, select 0 means none
// - manual request starts a channel only if it is armed
// - addresses lie in external data space
// - completion sets done flag, rearm or disarm
// - masked completion sets processor flag, irq
// - fixed count codes use count limit
// - variable codes add one, zero, two, three
// - count capped at limit when n large
// - elements are bytes or sixteen bit words
// - single modes move one element per trigger
// - block modes move whole count per trigger
// - arbitrate channels and processor by priority
// - high wins, normal alternates, low yields
// - abort write disarms channels written one
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module fcd_dma #(
  parameter int NCH = 5,
  parameter int NEVT = 30
) (
  input wire logic mclk, // system clock
  input wire logic reset, // sync reset, high
  input wire logic ce, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata_ff, // apb read data
  output logic pready_ff, // apb ready
  output logic pslverr_ff, // apb error, unmapped
  input wire logic [NEVT-1:0] evt_in, // trigger event pulses
  input wire logic cpu_req, // processor wants memory
  output logic mem_req_ff, // memory request
  output logic mem_we_ff, // memory write
  output logic mem_word_ff, // 16-bit element
  output logic [15:0] mem_addr_ff, // external data space address
  output logic [15:0] mem_wdata_ff, // write data
  input wire logic mem_ack, // request done, pulse
  input wire logic [15:0] mem_rdata, // read data with ack
  output logic irq_ff // transfer done interrupt
);
  localparam int CW = fcd_pkg::CFG_W;

  fcd_pkg::fcd_eng_t eng_ff;
  logic [NCH-1:0] arm_ff;
  logic [NCH-1:0] pend_ff;
  logic [NCH-1:0] done_ff;
  logic cpuf_ff;
  logic ien_ff;
  logic [15:0] src_ff [NCH];
  logic [15:0] dst_ff [NCH];
  logic [CW-1:0] cfg_ff [NCH];
  logic [15:0] asrc_ff [NCH];
  logic [15:0] adst_ff [NCH];
  logic [CW-1:0] acfg_ff [NCH];
  logic [15:0] sptr_ff [NCH];
  logic [15:0] dptr_ff [NCH];
  logic [12:0] cnt_ff [NCH];
  logic [12:0] tgt_ff [NCH];
  logic [2:0] cur_ff;

  ////////////////////////////////////////////////////////////////////
  // register decode

  wire wr_acc = psel & penable & pready_ff & pwrite;
  wire setup = psel & ~penable & ~pready_ff;
  wire hit_arm = paddr == fcd_pkg::ARM_OFS;
  wire hit_req = paddr == fcd_pkg::REQ_OFS;
  wire hit_done = paddr == fcd_pkg::DONE_OFS;
  wire hit_cpuf = paddr == fcd_pkg::CPUF_OFS;
  wire hit_stat = paddr == fcd_pkg::STAT_OFS;
  wire [11:0] ch_off = paddr - fcd_pkg::CH_BASE;
  wire [2:0] w_ch = ch_off[6:4];
  wire [3:0] w_fld = ch_off[3:0];
  wire in_ch = paddr >= fcd_pkg::CH_BASE &&
               paddr < fcd_pkg::CH_BASE + 12'(NCH) * fcd_pkg::CH_STRIDE;
  wire hit_src = in_ch && w_fld == fcd_pkg::SRC_OFS;
  wire hit_dst = in_ch && w_fld == fcd_pkg::DST_OFS;
  wire hit_cfg = in_ch && w_fld == fcd_pkg::CFG_OFS;
  wire mapped = hit_arm | hit_req | hit_done | hit_cpuf | hit_stat |
                hit_src | hit_dst | hit_cfg;
  wire wr_ok = wr_acc & mapped;

  wire abort_w = wr_ok & hit_arm & pwdata[fcd_pkg::ABORT_BIT];
  wire [NCH-1:0] abort_m = abort_w ? pwdata[NCH-1:0] : '0;
  wire [NCH-1:0] arm_set = (wr_ok & hit_arm & ~abort_w) ? pwdata[NCH-1:0] : '0;
  wire [NCH-1:0] req_w = (wr_ok & hit_req) ? pwdata[NCH-1:0] : '0;
  wire [NCH-1:0] done_clr = (wr_ok & hit_done) ? pwdata[NCH-1:0] : '0;
  wire cpuf_clr = wr_ok & hit_cpuf & pwdata[fcd_pkg::CPUF_FLAG_BIT];

  ////////////////////////////////////////////////////////////////////
  // loader and arbiter

  logic [NCH-1:0] load_done;
  logic [NCH-1:0] loading;
  logic gnt_vld;
  logic [2:0] gnt_ch;
  logic [NCH-1:0] evt_hit;
  logic [2*NCH-1:0] prio_flat;
  wire [NCH-1:0] want = (eng_ff == fcd_pkg::E_IDLE) ? pend_ff & arm_ff : '0;

  fcd_load #(.NCH(NCH)) u_load (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .start(arm_set),
    .done_ff(load_done),
    .loading(loading)
  );

  fcd_arb #(.NCH(NCH)) u_arb (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .want(want),
    .prio(prio_flat),
    .cpu_req(cpu_req),
    .gnt_vld(gnt_vld),
    .gnt_ch(gnt_ch)
  );

  // matching uses the active config, so a pending load keeps the old trigger
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    wire [fcd_pkg::EVENT_SOURCE_SELECT_W-1:0] tsel = acfg_ff[i][fcd_pkg::EVENT_SOURCE_SELECT_LSB +: fcd_pkg::EVENT_SOURCE_SELECT_W];
    assign evt_hit[i] = (tsel != '0 && int'(tsel) < NEVT && evt_in[tsel]) | req_w[i];
    assign prio_flat[2*i +: 2] = acfg_ff[i][fcd_pkg::PRIO_LSB +: 2];
  end

  ////////////////////////////////////////////////////////////////////
  // element engine decode

  wire [CW-1:0] ccfg = acfg_ff[cur_ff];
  wire c_word = ccfg[fcd_pkg::WIDTH_BIT];
  wire [1:0] c_mode = ccfg[fcd_pkg::MODE_LSB +: 2];
  wire c_block = c_mode[0];
  wire c_rep = c_mode[1];
  wire active = eng_ff != fcd_pkg::E_IDLE;
  wire abort_cur = active & abort_m[cur_ff];
  wire fin_ev = eng_ff == fcd_pkg::E_WR & mem_ack & ~abort_cur;
  wire last = cnt_ff[cur_ff] + 13'h1 >= tgt_ff[cur_ff];
  wire done_ev = fin_ev & last;
  wire [NCH-1:0] cur_m = NCH'(1) << cur_ff;
  wire [NCH-1:0] done_m = done_ev ? cur_m : '0;
  wire [NCH-1:0] disarm_m = (done_ev & ~c_rep) ? cur_m : '0;
  wire [NCH-1:0] elem_clr = (fin_ev & (~c_block | last)) ? cur_m : '0;
  wire [15:0] step = c_word ? 16'h0002 : 16'h0001;
  wire [15:0] wdat = c_word ? mem_rdata : {8'h00, mem_rdata[7:0]};

  // transfer count from the first element and the variable count code
  function automatic logic [12:0] calc_tgt(input logic [CW-1:0] c, input logic [15:0] d);
    logic [2:0] v;
    logic [12:0] lim;
    logic [12:0] n;
    logic [13:0] t;
    v = c[fcd_pkg::VARIABLE_COUNT_SELECT_LSB +: 3];
    lim = c[fcd_pkg::LEN_LSB +: fcd_pkg::LEN_W];
    if (c[fcd_pkg::WIDTH_BIT]) begin
      n = d[12:0];
    end else if (c[fcd_pkg::M8_BIT]) begin
      n = {5'h00, d[7:0]};
    end else begin
      n = {6'h00, d[6:0]};
    end
    t = {1'b0, n};
    case (v)
      fcd_pkg::VARIABLE_COUNT_SELECT_P1: t = t + 14'h0001;
      fcd_pkg::VARIABLE_COUNT_SELECT_P0: t = {1'b0, n};
      fcd_pkg::VARIABLE_COUNT_SELECT_P2: t = t + 14'h0002;
      fcd_pkg::VARIABLE_COUNT_SELECT_P3: t = t + 14'h0003;
      default: return lim;
    endcase
    return (n >= lim) ? lim : t[12:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // apb slave

  wire [31:0] stat_v = {24'h000000, active, cur_ff, 4'h0} | 32'(loading);
  wire [31:0] rd_v = hit_arm ? 32'(arm_ff) :
                     hit_done ? 32'(done_ff) :
                     hit_cpuf ? {30'h00000000, ien_ff, cpuf_ff} :
                     hit_stat ? stat_v :
                     hit_src ? {16'h0000, src_ff[w_ch]} :
                     hit_dst ? {16'h0000, dst_ff[w_ch]} :
                     hit_cfg ? 32'(cfg_ff[w_ch]) : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else if (ce) begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup) begin
        prdata_ff <= rd_v;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // arm, pending, flags

  always_ff @(posedge mclk) begin
    if (reset) begin
      arm_ff <= '0;
      pend_ff <= '0;
      done_ff <= '0;
      cpuf_ff <= 1'b0;
      ien_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      arm_ff <= (arm_ff | arm_set) & ~abort_m & ~disarm_m;
      pend_ff <= ((pend_ff & ~elem_clr) | (evt_hit & arm_ff)) & ~abort_m;
      done_ff <= (done_ff & ~done_clr) | done_m;
      cpuf_ff <= (cpuf_ff & ~cpuf_clr) | (done_ev & ccfg[fcd_pkg::IRQM_BIT]);
      if (wr_ok & hit_cpuf) begin
        ien_ff <= pwdata[fcd_pkg::CPUF_IEN_BIT];
      end
      irq_ff <= cpuf_ff & ien_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // channel registers, active copies, pointers

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < NCH; i++) begin
        src_ff[i] <= fcd_pkg::ADDR_RST;
        dst_ff[i] <= fcd_pkg::ADDR_RST;
        cfg_ff[i] <= fcd_pkg::CFG_RST;
        asrc_ff[i] <= fcd_pkg::ADDR_RST;
        adst_ff[i] <= fcd_pkg::ADDR_RST;
        acfg_ff[i] <= fcd_pkg::CFG_RST;
        sptr_ff[i] <= fcd_pkg::ADDR_RST;
        dptr_ff[i] <= fcd_pkg::ADDR_RST;
        cnt_ff[i] <= 13'h0000;
      end
    end else if (ce) begin
      if (wr_ok & hit_src) begin
        src_ff[w_ch] <= pwdata[15:0];
      end
      if (wr_ok & hit_dst) begin
        dst_ff[w_ch] <= pwdata[15:0];
      end
      if (wr_ok & hit_cfg) begin
        cfg_ff[w_ch] <= pwdata[CW-1:0];
      end
      for (int i = 0; i < NCH; i++) begin
        if (load_done[i]) begin
          asrc_ff[i] <= src_ff[i];
          adst_ff[i] <= dst_ff[i];
          acfg_ff[i] <= cfg_ff[i];
          sptr_ff[i] <= src_ff[i];
          dptr_ff[i] <= dst_ff[i];
          cnt_ff[i] <= 13'h0000;
        end
      end
      if (fin_ev) begin
        if (last) begin
          sptr_ff[cur_ff] <= asrc_ff[cur_ff];
          dptr_ff[cur_ff] <= adst_ff[cur_ff];
          cnt_ff[cur_ff] <= 13'h0000;
        end else begin
          sptr_ff[cur_ff] <= sptr_ff[cur_ff] + step;
          dptr_ff[cur_ff] <= dptr_ff[cur_ff] + step;
          cnt_ff[cur_ff] <= cnt_ff[cur_ff] + 13'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // element engine: read one element, then write it

  always_ff @(posedge mclk) begin
    if (reset) begin
      eng_ff <= fcd_pkg::E_IDLE;
      cur_ff <= 3'h0;
      for (int i = 0; i < NCH; i++) begin
        tgt_ff[i] <= 13'h0000;
      end
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_word_ff <= 1'b0;
      mem_addr_ff <= 16'h0000;
      mem_wdata_ff <= 16'h0000;
    end else if (ce) begin
      unique case (eng_ff)
        fcd_pkg::E_IDLE: begin
          if (gnt_vld) begin
            cur_ff <= gnt_ch;
            mem_req_ff <= 1'b1;
            mem_we_ff <= 1'b0;
            mem_word_ff <= acfg_ff[gnt_ch][fcd_pkg::WIDTH_BIT];
            mem_addr_ff <= sptr_ff[gnt_ch];
            eng_ff <= fcd_pkg::E_RD;
          end
        end
        fcd_pkg::E_RD: begin
          if (abort_cur) begin
            mem_req_ff <= 1'b0;
            eng_ff <= fcd_pkg::E_IDLE;
          end else if (mem_ack) begin
            if (cnt_ff[cur_ff] == 13'h0000) begin
              tgt_ff[cur_ff] <= calc_tgt(ccfg, mem_rdata);
            end
            mem_we_ff <= 1'b1;
            mem_addr_ff <= dptr_ff[cur_ff];
            mem_wdata_ff <= wdat;
            eng_ff <= fcd_pkg::E_WR;
          end
        end
        fcd_pkg::E_WR: begin
          if (abort_cur | mem_ack) begin
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            eng_ff <= fcd_pkg::E_IDLE;
          end
        end
        default: begin
          eng_ff <= fcd_pkg::E_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== hw/fcd_load.sv
// configuration loader: serves arm requests one channel at a time
// assumes start bits are one-cycle pulses from the register file
`timescale 1ns/1ps
`default_nettype none
module fcd_load #(
  parameter int NCH = 5
) (
  input wire logic mclk, // system clock
  input wire logic reset, // sync reset, high
  input wire logic ce, // clock enable
  input wire logic [NCH-1:0] start, // arm pulses
  output logic [NCH-1:0] done_ff, // config taken, pulse
  output logic [NCH-1:0] loading // waiting or loading
);
  logic [NCH-1:0] pend_ff;
  logic busy_ff;
  logic [2:0] cur_ff;
  logic [3:0] cnt_ff;
  logic [2:0] nxt_ch;
  logic [NCH-1:0] take;

  // channel 1 first, channel 0 last
  function automatic logic [2:0] pick(input logic [NCH-1:0] p);
    logic [2:0] r;
    r = 3'h0;
    for (int k = NCH - 1; k >= 1; k--) begin
      if (p[k]) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction

  assign nxt_ch = pick(pend_ff);
  assign take = (!busy_ff && pend_ff != '0) ? NCH'(1) << nxt_ch : '0;
  assign loading = pend_ff | (busy_ff ? NCH'(1) << cur_ff : '0);

  always_ff @(posedge mclk) begin
    if (reset) begin
      pend_ff <= '0;
      busy_ff <= 1'b0;
      cur_ff <= 3'h0;
      cnt_ff <= 4'h0;
      done_ff <= '0;
    end else if (ce) begin
      pend_ff <= (pend_ff & ~take) | start;
      done_ff <= '0;
      if (!busy_ff && pend_ff != '0) begin
        busy_ff <= 1'b1;
        cur_ff <= nxt_ch;
        cnt_ff <= fcd_pkg::LOAD_CYCLES - 4'h1;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
        if (cnt_ff == 4'h0) begin
          busy_ff <= 1'b0;
          done_ff <= NCH'(1) << cur_ff;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/fcd_pkg.sv
// constants, field layout and types of the five channel dma controller
// assumes a 32-bit apb register bus and a 16-bit memory port
package fcd_pkg;
  // register byte offsets
  localparam logic [11:0] ARM_OFS = 12'h000;
  localparam logic [11:0] REQ_OFS = 12'h004;
  localparam logic [11:0] DONE_OFS = 12'h008;
  localparam logic [11:0] CPUF_OFS = 12'h00C;
  localparam logic [11:0] STAT_OFS = 12'h010;
  localparam logic [11:0] CH_BASE = 12'h020;
  localparam logic [11:0] CH_STRIDE = 12'h010;
  localparam logic [3:0] SRC_OFS = 4'h0;
  localparam logic [3:0] DST_OFS = 4'h4;
  localparam logic [3:0] CFG_OFS = 4'h8;
  // bit positions
  localparam int ABORT_BIT = 7;
  localparam int CPUF_FLAG_BIT = 0;
  localparam int CPUF_IEN_BIT = 1;
  localparam int LEN_LSB = 0;
  localparam int LEN_W = 13;
  localparam int VARIABLE_COUNT_SELECT_LSB = 13;
  localparam int EVENT_SOURCE_SELECT_LSB = 16;
  localparam int EVENT_SOURCE_SELECT_W = 5;
  localparam int WIDTH_BIT = 21;
  localparam int M8_BIT = 22;
  localparam int MODE_LSB = 23;
  localparam int IRQM_BIT = 25;
  localparam int PRIO_LSB = 26;
  localparam int CFG_W = 28;
  // reset values
  localparam logic [CFG_W-1:0] CFG_RST = 28'h0000000;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  // timing
  localparam logic [3:0] LOAD_CYCLES = 4'h9;
  // encodings
  localparam logic [2:0] VARIABLE_COUNT_SELECT_P1 = 3'h1;
  localparam logic [2:0] VARIABLE_COUNT_SELECT_P0 = 3'h2;
  localparam logic [2:0] VARIABLE_COUNT_SELECT_P2 = 3'h3;
  localparam logic [2:0] VARIABLE_COUNT_SELECT_P3 = 3'h4;
  localparam logic [1:0] PRIO_LOW = 2'h0;
  localparam logic [1:0] PRIO_NORM = 2'h1;
  localparam logic [1:0] PRIO_HIGH = 2'h2;
  // bit 0 set: block form, bit 1 set: repeated form
  typedef enum logic [1:0] {MODE_SINGLE, MODE_BLOCK, MODE_RSINGLE, MODE_RBLOCK} fcd_mode_t;
  typedef enum logic [1:0] {E_IDLE, E_RD, E_WR} fcd_eng_t;
endpackage

// ===== tb/fcd_dma_monitor.sv
// checker on the ports of the dma controller top
// assumes ce stays high while it watches
`timescale 1ns/1ps
`default_nettype none
module fcd_dma_monitor (
  input wire logic mclk, // clock
  input wire logic reset, // sync reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pready_ff, // apb ready
  input wire logic pslverr_ff, // apb error
  input wire logic mem_req_ff, // memory request
  input wire logic mem_we_ff, // memory write
  input wire logic mem_word_ff, // word element
  input wire logic [15:0] mem_addr_ff, // address
  input wire logic [15:0] mem_wdata_ff, // write data
  input wire logic mem_ack, // memory done
  input wire logic [15:0] mem_rdata // read data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic [15:0] rd_last_ff;
  always_ff @(posedge mclk) begin
    rd_last_ff <= mem_rdata;
  end
  sequence s_wait;
    mem_req_ff && !mem_ack;
  endsequence
  sequence s_rd_ack;
    mem_req_ff && !mem_we_ff && mem_ack;
  endsequence
  sequence s_wr_ack;
    mem_req_ff && mem_we_ff && mem_ack;
  endsequence
  AST_REQ_HOLD: assert property (s_wait |=> !mem_req_ff ||
    ($stable(mem_addr_ff) && $stable(mem_we_ff) && $stable(mem_wdata_ff)))
    else $error("request changed before ack");
  AST_RD_THEN_WR: assert property (s_rd_ack |=> mem_req_ff && mem_we_ff)
    else $error("no write after read");
  AST_WR_DATA: assert property (s_rd_ack |=> mem_wdata_ff ==
    (mem_word_ff ? rd_last_ff : {8'h00, rd_last_ff[7:0]}))
    else $error("write data differs from read data");
  AST_WIDTH_KEPT: assert property (s_rd_ack |=> $stable(mem_word_ff))
    else $error("element width changed");
  AST_BYTE_UPPER: assert property (mem_req_ff && mem_we_ff && !mem_word_ff
    |-> mem_wdata_ff[15:8] == 8'h00)
    else $error("byte write upper bits set");
  AST_WR_END: assert property (s_wr_ack |=> !mem_req_ff)
    else $error("no idle cycle after element");
  AST_FIRST_RD: assert property ($rose(mem_req_ff) |-> !mem_we_ff)
    else $error("element started with a write");
  AST_APB_PULSE: assert property (pready_ff |=> !pready_ff)
    else $error("ready longer than one cycle");
  AST_APB_ERR: assert property (pslverr_ff |-> pready_ff)
    else $error("error without ready");
  AST_APB_SETUP: assert property ($rose(pready_ff) |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
endmodule
bind fcd_dma fcd_dma_monitor fcd_dma_monitor_i (.mclk(mclk), .reset(reset), .psel(psel),
  .penable(penable), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .mem_req_ff(mem_req_ff),
  .mem_we_ff(mem_we_ff), .mem_word_ff(mem_word_ff), .mem_addr_ff(mem_addr_ff),
  .mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
`default_nettype wire

// ===== tb/fcd_mem_model.sv
// memory partner: byte array, big-endian words, acks after a delay
// assumes one outstanding request, held until ack
`timescale 1ns/1ps
`default_nettype none
module fcd_mem_model (
  input wire logic mclk, // clock
  input wire logic slow, // add wait cycles
  input wire logic mem_req_ff, // request
  input wire logic mem_we_ff, // write
  input wire logic mem_word_ff, // word element
  input wire logic [15:0] mem_addr_ff, // address
  input wire logic [15:0] mem_wdata_ff, // write data
  output logic mem_ack, // done pulse
  output logic [15:0] mem_rdata // read data
);
  logic [7:0] mem [0:255];
  logic [7:0] a;
  int wait_cnt = 0;
  int wr_cnt = 0;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
  end
  // only the low part of the data space is modelled
  assign a = mem_addr_ff[7:0];
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req_ff && !mem_ack) begin
      if (wait_cnt >= (slow ? 3 : 0)) begin
        wait_cnt <= 0;
        mem_ack <= 1'b1;
        // every modelled place is writable
        if (mem_we_ff) begin
          wr_cnt <= wr_cnt + 1;
          mem[a] <= mem_word_ff ? mem_wdata_ff[15:8] : mem_wdata_ff[7:0];
          if (mem_word_ff) begin
            mem[a + 8'h01] <= mem_wdata_ff[7:0];
          end
        end else begin
          mem_rdata <= mem_word_ff ? {mem[a], mem[a + 8'h01]} : {~mem[a], mem[a]};
        end
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_fcd_dma.sv
// self-checking bench for the five channel dma controller
// assumes the memory partner model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_fcd_dma;
  logic mclk, reset, psel, penable, pwrite, cpu_req, slow, pready_ff, pslverr_ff, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_ff, rd;
  logic [29:0] evt_in;
  logic mem_req_ff, mem_we_ff, mem_word_ff, mem_ack, irq_ff;
  logic [15:0] mem_addr_ff, mem_wdata_ff, mem_rdata;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int base = 0;
  int vl [9] = '{0, 1, 2, 3, 4, 1, 7, 1, 1};
  int nn [9] = '{2, 2, 2, 2, 2, 9, 2, 131, 131};
  int m8 [9] = '{0, 0, 0, 0, 0, 0, 0, 0, 1};
  int ex [9] = '{8, 3, 2, 4, 5, 8, 8, 4, 8};
  fcd_dma fcd_dma_i (.mclk(mclk), .reset(reset), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .evt_in(evt_in), .cpu_req(cpu_req),
    .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff), .mem_word_ff(mem_word_ff),
    .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .irq_ff(irq_ff));
  fcd_mem_model fcd_mem_model_i (.mclk(mclk), .slow(slow), .mem_req_ff(mem_req_ff),
    .mem_we_ff(mem_we_ff), .mem_word_ff(mem_word_ff), .mem_addr_ff(mem_addr_ff),
    .mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready_ff !== 1'b1) @(posedge mclk);
    rd = prdata_ff;
    er = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  function automatic logic [11:0] ca(input int ch, input logic [3:0] o);
    return fcd_pkg::CH_BASE + fcd_pkg::CH_STRIDE * 12'(ch) + {8'h00, o};
  endfunction
  function automatic logic [31:0] mk(input int len, v, event_source_select, wd, m, md, irq, pr);
    return 32'(len) | 32'(v) << fcd_pkg::VARIABLE_COUNT_SELECT_LSB | 32'(event_source_select) << fcd_pkg::EVENT_SOURCE_SELECT_LSB
      | 32'(wd) << fcd_pkg::WIDTH_BIT | 32'(m) << fcd_pkg::M8_BIT
      | 32'(md) << fcd_pkg::MODE_LSB | 32'(irq) << fcd_pkg::IRQM_BIT
      | 32'(pr) << fcd_pkg::PRIO_LSB;
  endfunction
  function automatic int nw();
    return fcd_mem_model_i.wr_cnt - base;
  endfunction
  task automatic prep(input int ch, input logic [15:0] s, d, input logic [31:0] c);
    base = fcd_mem_model_i.wr_cnt;
    apb(1'b1, ca(ch, fcd_pkg::SRC_OFS), {16'h0000, s});
    apb(1'b1, ca(ch, fcd_pkg::DST_OFS), {16'h0000, d});
    apb(1'b1, ca(ch, fcd_pkg::CFG_OFS), c);
    apb(1'b1, fcd_pkg::ARM_OFS, 32'h1 << ch);
    repeat (12) @(posedge mclk);
  endtask
  task automatic wait_done(input int ch);
    rd = 32'h0;
    while (rd[ch] !== 1'b1) begin
      apb(1'b0, fcd_pkg::DONE_OFS, 32'h0);
    end
  endtask
  task automatic pulse(input int k);
    evt_in <= 30'h1 << k;
    @(posedge mclk);
    evt_in <= 30'h0;
    repeat (30) @(posedge mclk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, cpu_req, slow, paddr, pwdata, evt_in} = '0;
    reset = 1'b1;
    for (int i = 0; i < 256; i++) fcd_mem_model_i.mem[i] = 8'(i) ^ 8'h5A;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    apb(1'b0, fcd_pkg::ARM_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, ca(2, fcd_pkg::CFG_OFS), 32'h0);
    `CHK(rd, {4'h0, fcd_pkg::CFG_RST})
    apb(1'b0, 12'h100, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    base = fcd_mem_model_i.wr_cnt;
    apb(1'b1, fcd_pkg::REQ_OFS, 32'h4);
    repeat (30) @(posedge mclk);
    `CHK(nw(), 0)
    // every transfer mode on channel 4
    for (int m = 0; m < 4; m++) begin
      prep(4, 16'h0010, 16'h0080, mk(2, 0, 0, 0, 0, m, 0, 0));
      apb(1'b1, fcd_pkg::REQ_OFS, 32'h10);
      repeat (20) @(posedge mclk);
      `CHK(nw(), m[0] ? 2 : 1)
      if (!m[0]) apb(1'b1, fcd_pkg::REQ_OFS, 32'h10);
      wait_done(4);
      `CHK(rd[4], 1'b1)
      `CHK(fcd_mem_model_i.mem[8'h81], 8'h11 ^ 8'h5A)
      apb(1'b0, fcd_pkg::ARM_OFS, 32'h0);
      `CHK(rd[4], m[1])
      apb(1'b1, fcd_pkg::DONE_OFS, 32'h10);
      apb(1'b1, fcd_pkg::ARM_OFS, 32'h90);
    end
    apb(1'b0, fcd_pkg::ARM_OFS, 32'h0);
    `CHK(rd[4:0], 5'h00)
    // count codes on channel 0, prompt and slow memory in turn
    for (int i = 0; i < 9; i++) begin
      fcd_mem_model_i.mem[8'h20] = 8'(nn[i]);
      slow <= i[0];
      prep(0, 16'h0020, 16'h0040, mk(8, vl[i], 0, 0, m8[i], 1, 0, 0));
      apb(1'b1, fcd_pkg::REQ_OFS, 32'h1);
      wait_done(0);
      `CHK(nw(), ex[i])
      apb(1'b1, fcd_pkg::DONE_OFS, 32'h1);
    end
    // event trigger, words and interrupt on channel 3
    prep(3, 16'h0060, 16'h0070, mk(2, 0, 5, 1, 0, 0, 1, 0));
    pulse(4);
    `CHK(nw(), 0)
    pulse(5);
    `CHK(nw(), 1)
    pulse(5);
    wait_done(3);
    `CHK(rd[3], 1'b1)
    `CHK({fcd_mem_model_i.mem[8'h72], fcd_mem_model_i.mem[8'h73]}, 16'h6263 ^ 16'h5A5A)
    apb(1'b0, fcd_pkg::CPUF_OFS, 32'h0);
    `CHK({irq_ff, rd[1:0]}, 3'b001)
    apb(1'b1, fcd_pkg::CPUF_OFS, 32'h2);
    @(posedge mclk);
    `CHK(irq_ff, 1'b1)
    apb(1'b1, fcd_pkg::CPUF_OFS, 32'h3);
    repeat (2) @(posedge mclk);
    `CHK(irq_ff, 1'b0)
    apb(1'b0, fcd_pkg::ARM_OFS, 32'h0);
    `CHK(rd[3], 1'b0)
    // two channels armed together, one aborted
    apb(1'b1, fcd_pkg::ARM_OFS, 32'h3);
    repeat (12) @(posedge mclk);
    apb(1'b0, fcd_pkg::STAT_OFS, 32'h0);
    `CHK(rd[1:0], 2'b01)
    repeat (10) @(posedge mclk);
    apb(1'b1, fcd_pkg::ARM_OFS, 32'h82);
    apb(1'b0, fcd_pkg::ARM_OFS, 32'h0);
    `CHK(rd[4:0], 5'h01)
    apb(1'b1, fcd_pkg::ARM_OFS, 32'h81);
    // low yields to the processor, normal wins every second try, high always
    for (int p = 0; p < 3; p++) begin
      cpu_req <= 1'b1;
      prep(1, 16'h0010, 16'h0090, mk(1, 0, 0, 0, 0, 1, 0, p));
      apb(1'b1, fcd_pkg::REQ_OFS, 32'h2);
      repeat (30) @(posedge mclk);
      `CHK(nw(), (p + 1) / 2)
      cpu_req <= 1'b0;
      wait_done(1);
      `CHK(rd[1], 1'b1)
      apb(1'b1, fcd_pkg::DONE_OFS, 32'h2);
    end
    complete_run();
  end
endmodule
`default_nettype wire
